// ===== hdl/adc_ctl_pkg.sv
// constants, field layout and carrier types for the converter control block
// assumes word-indexed registers: byte address is four times the index
`default_nettype none

package adc_ctl_pkg;

  localparam int REG_IDX_W = 10;
  localparam int DATA_W = 14;
  localparam int SEL_W = 5;
  localparam int IRQ_W = 3;

  // register indices; byte address = index * 4
  localparam logic [REG_IDX_W-1:0] IDX_CONFIG = 10'h001;
  localparam logic [REG_IDX_W-1:0] IDX_CAL_CTL = 10'h005;
  localparam logic [REG_IDX_W-1:0] IDX_CH1_CTL = 10'h006;
  localparam logic [REG_IDX_W-1:0] IDX_CH1_DATL = 10'h007;
  localparam logic [REG_IDX_W-1:0] IDX_CH1_DATH = 10'h008;
  localparam logic [REG_IDX_W-1:0] IDX_HS_DATL = 10'h014;
  localparam logic [REG_IDX_W-1:0] IDX_HS_DATH = 10'h015;
  localparam logic [REG_IDX_W-1:0] IDX_GE_DATL = 10'h016;
  localparam logic [REG_IDX_W-1:0] IDX_GE_DATH = 10'h017;
  localparam logic [REG_IDX_W-1:0] IDX_IRQ_STAT = 10'h020;
  localparam logic [REG_IDX_W-1:0] IDX_IRQ_MASK = 10'h021;

  // field positions
  localparam int CFG_EN_BIT = 0;
  localparam int HS_VALID_BIT = 5;
  localparam int GE_VALID_BIT = 4;
  localparam int HS_EN_BIT = 1;
  localparam int GE_EN_BIT = 0;
  localparam int CH_VALID_BIT = 7;
  localparam int CH_IRQ_EN_BIT = 5;
  localparam int IRQ_CH1_BIT = 0;
  localparam int IRQ_HS_BIT = 1;
  localparam int IRQ_GE_BIT = 2;

  // values after reset, and the highest usable selector code
  localparam logic CFG_EN_RST = 1'h0;
  localparam logic [SEL_W-1:0] SEL_DISABLED = 5'h1f;
  localparam logic [SEL_W-1:0] SEL_MAX = 5'h0d;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h1;
  localparam logic [DATA_W-1:0] DATA_RST = 14'h0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    KIND_CHAN,
    KIND_HSCAL,
    KIND_GECAL
  } conv_kind_type;

  typedef struct packed {
    logic power;
    logic req;
    conv_kind_type kind;
    logic [SEL_W-1:0] sel;
  } conv_req_type;

  typedef struct packed {
    logic wr;
    logic [REG_IDX_W-1:0] widx;
    logic [7:0] wdata;
    logic [REG_IDX_W-1:0] ridx;
  } reg_req_type;

  function automatic logic reg_mapped(input logic [REG_IDX_W-1:0] idx);
    case (idx)
      IDX_CONFIG, IDX_CAL_CTL, IDX_CH1_CTL, IDX_CH1_DATL, IDX_CH1_DATH,
      IDX_HS_DATL, IDX_HS_DATH, IDX_GE_DATL, IDX_GE_DATH,
      IDX_IRQ_STAT, IDX_IRQ_MASK: reg_mapped = 1'h1;
      default: reg_mapped = 1'h0;
    endcase
  endfunction

endpackage

`default_nettype wire

// ===== hdl/axil_reg_slave.sv
// axi4-lite slave turning bus beats into one-cycle register strokes
// assumes the register owner answers read data combinationally on ridx
`default_nettype none

module axil_reg_slave #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output adc_ctl_pkg::reg_req_type req, // register stroke
  input wire logic [7:0] rd_data // data at req.ridx
);

  logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
  logic aw_have_ff, nxt_aw_have, w_have_ff, nxt_w_have;
  logic [7:0] wdata_ff, nxt_wdata;
  logic wen_ff, nxt_wen;
  logic awready_ff, nxt_awready, wready_ff, nxt_wready;
  logic bvalid_ff, nxt_bvalid, arready_ff, nxt_arready;
  logic rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic wr_fire, rd_fire;
  logic [adc_ctl_pkg::REG_IDX_W-1:0] widx, ridx;

  assign widx = adc_ctl_pkg::REG_IDX_W'(awaddr_ff >> 2);
  assign ridx = adc_ctl_pkg::REG_IDX_W'(s_axi_araddr >> 2);

  always_comb begin
    nxt_awaddr = awaddr_ff;
    nxt_aw_have = aw_have_ff;
    nxt_w_have = w_have_ff;
    nxt_wdata = wdata_ff;
    nxt_wen = wen_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    if (s_axi_awvalid && awready_ff) begin
      nxt_awaddr = s_axi_awaddr;
      nxt_aw_have = 1'h1;
    end
    // only byte lane 0 carries register bits
    if (s_axi_wvalid && wready_ff) begin
      nxt_wdata = s_axi_wdata[7:0];
      nxt_wen = s_axi_wstrb[0];
      nxt_w_have = 1'h1;
    end
    wr_fire = aw_have_ff && w_have_ff && !bvalid_ff;
    if (wr_fire) begin
      nxt_aw_have = 1'h0;
      nxt_w_have = 1'h0;
      nxt_bvalid = 1'h1;
      nxt_bresp = adc_ctl_pkg::reg_mapped(widx) ? adc_ctl_pkg::RESP_OKAY
                                               : adc_ctl_pkg::RESP_SLVERR;
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'h0;
    end
    rd_fire = s_axi_arvalid && arready_ff;
    if (rd_fire) begin
      nxt_rvalid = 1'h1;
      nxt_rdata = {24'h000000, rd_data};
      nxt_rresp = adc_ctl_pkg::reg_mapped(ridx) ? adc_ctl_pkg::RESP_OKAY
                                               : adc_ctl_pkg::RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'h0;
    end
    nxt_awready = !nxt_aw_have && !nxt_bvalid;
    nxt_wready = !nxt_w_have && !nxt_bvalid;
    nxt_arready = !nxt_rvalid;
    req.wr = wr_fire && wen_ff && adc_ctl_pkg::reg_mapped(widx);
    req.widx = widx;
    req.wdata = wdata_ff;
    req.ridx = ridx;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_ff <= '0;
      aw_have_ff <= 1'h0;
      w_have_ff <= 1'h0;
      wdata_ff <= 8'h00;
      wen_ff <= 1'h0;
      awready_ff <= 1'h1;
      wready_ff <= 1'h1;
      bvalid_ff <= 1'h0;
      bresp_ff <= adc_ctl_pkg::RESP_OKAY;
      arready_ff <= 1'h1;
      rvalid_ff <= 1'h0;
      rresp_ff <= adc_ctl_pkg::RESP_OKAY;
      rdata_ff <= 32'h00000000;
    end else begin
      awaddr_ff <= nxt_awaddr;
      aw_have_ff <= nxt_aw_have;
      w_have_ff <= nxt_w_have;
      wdata_ff <= nxt_wdata;
      wen_ff <= nxt_wen;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

endmodule // axil_reg_slave

`default_nettype wire

// ===== hdl/adc_cal_chan_ctl.sv
// converter calibration and voltage channel 1 control, axi4-lite registers
// assumes the converter core shares aclk and pulses conv_done for one cycle
//
// Behaviour
// R1: the end of any calibration conversion sets the high-scale valid flag.
// R2: both calibration valid flags clear on module disable or a written one.
// R3: high-scale valid data is gain data after a gain run, else offset data.
// R4: a finished gain-error calibration sets the gain-error valid flag.
// R5: writing one to the high-scale enable starts it only if gain enable is 0.
// R6: a finished high-scale run stores its result and clears its enable.
// R7: gain enable starts one run that stores, flags and clears the enable.
// R8: each finished channel 1 conversion sets the channel valid flag.
// R9: the channel valid flag clears on module disable or a written one.
// R10: the channel interrupt enable lets a data-valid event raise the irq.
// R11: the 5-bit selector picks inputs 0 to 13, other codes are reserved.
// R12: the all-ones selector disables the channel and is the reset value.
// R13: software sets the selector before a measurement starts.
// R14: config bit 0 enables and powers the converter, off after reset.
// R15: the 14-bit result reads as a low byte and a 6-bit high part.
// R16: the irq is a level held while an unmasked irq status bit stays set.
//
// The AXI4-Lite slave port is this design's own decision.
`default_nettype none

module adc_cal_chan_ctl #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk, // clock, 40 mhz
  input wire logic aresetn, // sync reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output adc_ctl_pkg::conv_req_type conv, // request to converter core
  input wire logic conv_done, // core result strobe
  input wire logic [adc_ctl_pkg::DATA_W-1:0] conv_data, // core result
  output logic irq // converter interrupt, level
);

  typedef enum logic {ST_IDLE, ST_BUSY} seq_state_type;

  localparam int DW = adc_ctl_pkg::DATA_W;
  localparam int SW = adc_ctl_pkg::SEL_W;
  localparam int IW = adc_ctl_pkg::IRQ_W;

  adc_ctl_pkg::reg_req_type req;
  logic [7:0] rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave

  axil_reg_slave #(.ADDR_W(ADDR_W)) u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .req(req),
    .rd_data(rd_data)
  );

  function automatic logic sel_usable(input logic [SW-1:0] sel);
    sel_usable = (sel <= adc_ctl_pkg::SEL_MAX);
  endfunction

  function automatic logic wr_to(input adc_ctl_pkg::reg_req_type r,
                                 input logic [adc_ctl_pkg::REG_IDX_W-1:0] i);
    wr_to = r.wr && (r.widx == i);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers and sequencer state

  logic cfg_en_ff, nxt_cfg_en;
  logic hs_valid_ff, nxt_hs_valid, ge_valid_ff, nxt_ge_valid;
  logic hs_en_ff, nxt_hs_en, ge_en_ff, nxt_ge_en;
  logic ch_valid_ff, nxt_ch_valid, ch_irq_en_ff, nxt_ch_irq_en;
  logic [SW-1:0] sel_ff, nxt_sel;
  logic [DW-1:0] ch_res_ff, nxt_ch_res, hs_res_ff, nxt_hs_res;
  logic [DW-1:0] ge_res_ff, nxt_ge_res;
  logic [IW-1:0] irq_stat_ff, nxt_irq_stat, irq_mask_ff, nxt_irq_mask;
  logic irq_ff, nxt_irq;
  seq_state_type state_ff, nxt_state;
  adc_ctl_pkg::conv_req_type conv_ff, nxt_conv;

  logic done_ok, chan_done, hs_done, ge_done, wr_cal, wr_ch, ch_clear;

  assign done_ok = (state_ff == ST_BUSY) && conv_done && cfg_en_ff;
  assign chan_done = done_ok && (conv_ff.kind == adc_ctl_pkg::KIND_CHAN);
  assign hs_done = done_ok && (conv_ff.kind == adc_ctl_pkg::KIND_HSCAL);
  assign ge_done = done_ok && (conv_ff.kind == adc_ctl_pkg::KIND_GECAL);
  assign wr_cal = wr_to(req, adc_ctl_pkg::IDX_CAL_CTL);
  assign wr_ch = wr_to(req, adc_ctl_pkg::IDX_CH1_CTL);
  assign ch_clear = !cfg_en_ff ||
                    (wr_ch && req.wdata[adc_ctl_pkg::CH_VALID_BIT]);

  ////////////////////////////////////////////////////////////////////////////
  // register file next state

  always_comb begin
    nxt_cfg_en = cfg_en_ff;
    nxt_hs_en = hs_en_ff;
    nxt_ge_en = ge_en_ff;
    nxt_ch_irq_en = ch_irq_en_ff;
    nxt_sel = sel_ff;
    nxt_ch_res = ch_res_ff;
    nxt_hs_res = hs_res_ff;
    nxt_ge_res = ge_res_ff;
    nxt_irq_mask = irq_mask_ff;
    if (wr_to(req, adc_ctl_pkg::IDX_CONFIG)) begin
      nxt_cfg_en = req.wdata[adc_ctl_pkg::CFG_EN_BIT]; // R14
    end
    // completion clears the enables before a same-cycle write lands
    if (hs_done) begin
      nxt_hs_en = 1'h0; // R6
      nxt_hs_res = conv_data; // R6
    end
    // gain data also lands in the high-scale buffer it flags
    if (ge_done) begin
      nxt_ge_en = 1'h0; // R7
      nxt_ge_res = conv_data; // R7
      nxt_hs_res = conv_data; // R3
    end
    if (wr_cal) begin
      nxt_ge_en = req.wdata[adc_ctl_pkg::GE_EN_BIT]; // R7
      nxt_hs_en = req.wdata[adc_ctl_pkg::HS_EN_BIT] &&
                  !ge_en_ff && !req.wdata[adc_ctl_pkg::GE_EN_BIT]; // R5
    end
    if (wr_ch) begin
      nxt_ch_irq_en = req.wdata[adc_ctl_pkg::CH_IRQ_EN_BIT]; // R10
      nxt_sel = req.wdata[SW-1:0]; // R11
    end
    if (wr_to(req, adc_ctl_pkg::IDX_IRQ_MASK)) begin
      nxt_irq_mask = req.wdata[IW-1:0];
    end
    if (chan_done) begin
      nxt_ch_res = conv_data; // R8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags: a set in the clearing cycle wins

  always_comb begin
    nxt_hs_valid = hs_valid_ff;
    nxt_ge_valid = ge_valid_ff;
    nxt_ch_valid = ch_valid_ff;
    nxt_irq_stat = irq_stat_ff;
    if (!cfg_en_ff) begin
      nxt_hs_valid = 1'h0; // R2
      nxt_ge_valid = 1'h0; // R2
    end
    if (wr_cal && req.wdata[adc_ctl_pkg::HS_VALID_BIT]) begin
      nxt_hs_valid = 1'h0; // R2
    end
    if (wr_cal && req.wdata[adc_ctl_pkg::GE_VALID_BIT]) begin
      nxt_ge_valid = 1'h0; // R2
    end
    if (ch_clear) begin
      nxt_ch_valid = 1'h0; // R9
      nxt_irq_stat[adc_ctl_pkg::IRQ_CH1_BIT] = 1'h0; // R16
    end
    if (wr_to(req, adc_ctl_pkg::IDX_IRQ_STAT)) begin
      nxt_irq_stat = nxt_irq_stat & ~req.wdata[IW-1:0];
    end
    if (hs_done || ge_done) begin
      nxt_hs_valid = 1'h1; // R1
    end
    if (ge_done) begin
      nxt_ge_valid = 1'h1; // R4
      nxt_irq_stat[adc_ctl_pkg::IRQ_GE_BIT] = 1'h1;
    end
    if (hs_done) begin
      nxt_irq_stat[adc_ctl_pkg::IRQ_HS_BIT] = 1'h1;
    end
    if (chan_done) begin
      nxt_ch_valid = 1'h1; // R8
      if (ch_irq_en_ff) begin
        nxt_irq_stat[adc_ctl_pkg::IRQ_CH1_BIT] = 1'h1; // R10
      end
    end
    nxt_irq = |(irq_stat_ff & irq_mask_ff); // R16
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer: gain run, then high-scale run, then channel 1

  always_comb begin
    nxt_state = state_ff;
    nxt_conv = conv_ff;
    nxt_conv.power = cfg_en_ff; // R14
    case (state_ff)
      ST_IDLE: begin
        nxt_conv.req = 1'h0;
        if (cfg_en_ff) begin
          if (ge_en_ff) begin
            nxt_conv.req = 1'h1; // R7
            nxt_conv.kind = adc_ctl_pkg::KIND_GECAL;
            nxt_state = ST_BUSY;
          end else if (hs_en_ff) begin
            nxt_conv.req = 1'h1; // R5
            nxt_conv.kind = adc_ctl_pkg::KIND_HSCAL;
            nxt_state = ST_BUSY;
          end else if (sel_usable(sel_ff)) begin
            // reserved codes and the all-ones code never convert
            nxt_conv.req = 1'h1; // R12
            nxt_conv.kind = adc_ctl_pkg::KIND_CHAN;
            nxt_conv.sel = sel_ff; // R11
            nxt_state = ST_BUSY;
          end
        end
      end
      ST_BUSY: begin
        if (!cfg_en_ff || conv_done) begin
          nxt_conv.req = 1'h0;
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_conv.req = 1'h0;
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_en_ff <= adc_ctl_pkg::CFG_EN_RST;
      hs_valid_ff <= 1'h0;
      ge_valid_ff <= 1'h0;
      hs_en_ff <= 1'h0;
      ge_en_ff <= 1'h0;
      ch_valid_ff <= 1'h0;
      ch_irq_en_ff <= 1'h0;
      sel_ff <= adc_ctl_pkg::SEL_DISABLED; // R12
      ch_res_ff <= adc_ctl_pkg::DATA_RST;
      hs_res_ff <= adc_ctl_pkg::DATA_RST;
      ge_res_ff <= adc_ctl_pkg::DATA_RST;
      irq_stat_ff <= '0;
      irq_mask_ff <= adc_ctl_pkg::IRQ_MASK_RST;
      irq_ff <= 1'h0;
      state_ff <= ST_IDLE;
      conv_ff <= '{power: 1'h0, req: 1'h0, kind: adc_ctl_pkg::KIND_CHAN,
                   sel: adc_ctl_pkg::SEL_DISABLED};
    end else begin
      cfg_en_ff <= nxt_cfg_en;
      hs_valid_ff <= nxt_hs_valid;
      ge_valid_ff <= nxt_ge_valid;
      hs_en_ff <= nxt_hs_en;
      ge_en_ff <= nxt_ge_en;
      ch_valid_ff <= nxt_ch_valid;
      ch_irq_en_ff <= nxt_ch_irq_en;
      sel_ff <= nxt_sel;
      ch_res_ff <= nxt_ch_res;
      hs_res_ff <= nxt_hs_res;
      ge_res_ff <= nxt_ge_res;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
      irq_ff <= nxt_irq;
      state_ff <= nxt_state;
      conv_ff <= nxt_conv;
    end
  end

  assign conv = conv_ff;
  assign irq = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // read mux; reserved bits read zero

  always_comb begin
    case (req.ridx)
      adc_ctl_pkg::IDX_CONFIG: rd_data = {7'h00, cfg_en_ff};
      adc_ctl_pkg::IDX_CAL_CTL:
        rd_data = {2'h0, hs_valid_ff, ge_valid_ff, 2'h0, hs_en_ff, ge_en_ff};
      adc_ctl_pkg::IDX_CH1_CTL:
        rd_data = {ch_valid_ff, 1'h0, ch_irq_en_ff, sel_ff};
      adc_ctl_pkg::IDX_CH1_DATL: rd_data = ch_res_ff[7:0]; // R15
      adc_ctl_pkg::IDX_CH1_DATH: rd_data = {2'h0, ch_res_ff[DW-1:8]}; // R15
      adc_ctl_pkg::IDX_HS_DATL: rd_data = hs_res_ff[7:0];
      adc_ctl_pkg::IDX_HS_DATH: rd_data = {2'h0, hs_res_ff[DW-1:8]};
      adc_ctl_pkg::IDX_GE_DATL: rd_data = ge_res_ff[7:0];
      adc_ctl_pkg::IDX_GE_DATH: rd_data = {2'h0, ge_res_ff[DW-1:8]};
      adc_ctl_pkg::IDX_IRQ_STAT: rd_data = {5'h00, irq_stat_ff};
      adc_ctl_pkg::IDX_IRQ_MASK: rd_data = {5'h00, irq_mask_ff};
      default: rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_cal_done;
    hs_done || ge_done;
  endsequence
  sequence s_gain_stored;
    ge_valid_ff && hs_res_ff == ge_res_ff && ge_res_ff == $past(conv_data);
  endsequence

  a_hs_valid_set: assert property (s_cal_done |=> hs_valid_ff) // R1
    else $error("high-scale valid not set after calibration");
  a_gain_flags: assert property (ge_done |=> s_gain_stored) // R4
    else $error("gain result or flag missing after gain run");
  a_cal_clear_off: assert property ( // R2
    !cfg_en_ff |=> !hs_valid_ff && !ge_valid_ff)
    else $error("calibration flags survive module disable");
  a_hs_start_gate: assert property ( // R5
    wr_cal && req.wdata[adc_ctl_pkg::HS_EN_BIT] && ge_en_ff
    |=> !hs_en_ff)
    else $error("high-scale enable set while gain enable high");
  a_hs_autoclear: assert property ( // R6
    hs_done && !wr_cal |=> !hs_en_ff && hs_res_ff == $past(conv_data))
    else $error("high-scale run did not store and clear");
  a_ge_autoclear: assert property (ge_done && !wr_cal |=> !ge_en_ff) // R7
    else $error("gain enable not cleared after run");
  a_chan_result: assert property ( // R8
    chan_done |=> ch_valid_ff && ch_res_ff == $past(conv_data))
    else $error("channel result or valid flag missing");
  a_chan_clear: assert property (ch_clear && !chan_done |=> !ch_valid_ff) // R9
    else $error("channel valid flag not cleared");
  a_sel_range: assert property ( // R11
    conv_ff.req && conv_ff.kind == adc_ctl_pkg::KIND_CHAN
    |-> conv_ff.sel <= adc_ctl_pkg::SEL_MAX)
    else $error("conversion started on reserved input");
  a_sel_off: assert property ( // R12
    state_ff == ST_IDLE && sel_ff == adc_ctl_pkg::SEL_DISABLED &&
    !ge_en_ff && !hs_en_ff |=> !conv_ff.req)
    else $error("disabled channel started a conversion");
  a_irq_level: assert property ( // R16
    chan_done && ch_irq_en_ff && irq_mask_ff[adc_ctl_pkg::IRQ_CH1_BIT]
    ##1 !ch_clear |=> irq_ff)
    else $error("channel interrupt not raised");
  a_irq_drop: assert property (irq_stat_ff == '0 |=> !irq_ff) // R16
    else $error("interrupt high with no status set");
  a_power_follow: assert property (conv_ff.power == $past(cfg_en_ff)) // R14
    else $error("converter power does not track module enable");

endmodule // adc_cal_chan_ctl

`default_nettype wire

// ===== verification/conv_core_model.sv
// converter core stand-in: answers each request after a fixed delay
// assumes a request holds until the strobe that it gets back
`default_nettype none

module conv_core_model #(
  parameter int DLY = 20
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire adc_ctl_pkg::conv_req_type conv, // request
  output logic conv_done, // one-cycle strobe
  output logic [13:0] conv_data // result
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;
  logic [13:0] res;
  // calibration runs ignore the selector, so their data never depends on it
  assign res = {conv.kind, 7'h2a,
                (conv.kind == adc_ctl_pkg::KIND_CHAN) ? conv.sel : 5'h1f};
  // junk outside the strobe, so a late sample never looks right
  assign conv_data = conv_done ? res : ~res;
  always_ff @(posedge aclk) begin
    if (!aresetn || !conv.req || conv_done) begin
      cnt <= 0;
      conv_done <= 1'h0;
    end else begin
      cnt <= cnt + 1;
      conv_done <= (cnt == DLY);
    end
  end
endmodule // conv_core_model

`default_nettype wire

// ===== verification/adc_calibration_and_channel_control_tb_top.sv
// bench for the converter control block, registers over axi4-lite
// assumes one clock; the core model answers after a fixed delay
`default_nettype none

module adc_calibration_and_channel_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DLY = 20;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, conv_done, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [13:0] conv_data;
  adc_ctl_pkg::conv_req_type conv;
  int miscompares = 0;
  int check_count = 0;

  adc_cal_chan_ctl uut (.*);
  conv_core_model #(.DLY(DLY)) core (.*);

  always #12.5 aclk = ~aclk;
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [9:0] i, input logic [7:0] d,
                    input logic [1:0] er = 2'h0);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    fork
      begin
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'h0;
      end
      begin
        do @(posedge aclk); while (!s_axi_wready);
        s_axi_wvalid <= 1'h0;
      end
    join
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk($sformatf("bresp %h", i), s_axi_bresp, er);
    // one edge apart, so a following call never re-drives a strobe at once
    @(posedge aclk);
  endtask

  task automatic rd(input logic [9:0] i, input logic [7:0] e,
                    input logic [1:0] er = 2'h0);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk($sformatf("reg %h", i), s_axi_rdata, {24'h000000, e});
    chk($sformatf("rresp %h", i), s_axi_rresp, er);
    @(posedge aclk);
  endtask

  task automatic summarize;
    if (miscompares == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // a finished conversion lands well inside this span
  task automatic settle;
    repeat (DLY + 10) @(posedge aclk);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(10'h001, 8'h00);
    rd(10'h005, 8'h00);
    rd(10'h006, 8'h1f);
    rd(10'h021, 8'h01);
    rd(10'h3ff, 8'h00, 2'h2);
    wr(10'h3ff, 8'hff, 2'h2);
    wr(10'h001, 8'h01);
    settle;
    chk("req", conv.req, 1'h0);
    chk("power", conv.power, 1'h1);
    wr(10'h006, 8'h23);
    settle;
    chk("irq", irq, 1'h1);
    rd(10'h006, 8'ha3);
    rd(10'h007, 8'h43);
    rd(10'h008, 8'h05);
    wr(10'h006, 8'h3f);
    settle;
    wr(10'h006, 8'hbf);
    rd(10'h006, 8'h3f);
    chk("irq", irq, 1'h0);
    wr(10'h006, 8'h03);
    settle;
    chk("irq", irq, 1'h0);
    wr(10'h006, 8'h1f);
    settle;
    wr(10'h001, 8'h00);
    rd(10'h006, 8'h1f);
    chk("power", conv.power, 1'h0);
    wr(10'h001, 8'h01);
    wr(10'h021, 8'h02);
    wr(10'h005, 8'h02);
    settle;
    rd(10'h005, 8'h20);
    rd(10'h014, 8'h5f);
    rd(10'h015, 8'h15);
    chk("irq", irq, 1'h1);
    rd(10'h020, 8'h02);
    wr(10'h020, 8'h02);
    wr(10'h005, 8'h20);
    rd(10'h005, 8'h00);
    chk("irq", irq, 1'h0);
    wr(10'h005, 8'h03);
    wr(10'h005, 8'h03);
    rd(10'h005, 8'h01);
    settle;
    rd(10'h005, 8'h30);
    rd(10'h016, 8'h5f);
    rd(10'h017, 8'h25);
    rd(10'h015, 8'h25);
    rd(10'h020, 8'h04);
    wr(10'h001, 8'h00);
    rd(10'h005, 8'h00);
    summarize;
  end

  initial begin
    repeat (5000) @(posedge aclk);
    miscompares++;
    summarize;
  end
endmodule // adc_calibration_and_channel_control_tb_top

`default_nettype wire
